// ---- rtl/cacs_conv.sv ----
// converter end: forced stop, fault-ok and warning outputs, contactor coil drive
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module cacs_conv #(
  parameter int unsigned FAULT_OK_CYCLES_P = cacs_pkg::FAULT_OK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  cacs_link_if.conv       link,
  input  wire logic       forced_stop_in_i,        // pin, high = run permitted
  input  wire logic       power_ok_i,              // pin, control power present
  input  wire logic       prot_trip_i,             // pin, protective condition
  input  wire logic       warn_cond_i,             // pin, warning condition
  input  wire logic [1:0] contactor_ctrl_select_i, // static configuration
  output logic            fault_ok_out_o,
  output logic            warning_out_o,
  output logic            contactor_coil_switch_o
);
  import cacs_pkg::*;

  // terminal count cut to counter width once, so the compare is width-clean
  localparam logic [CNT_W-1:0] DELAY_TC = CNT_W'(FAULT_OK_CYCLES_P - 1);

  typedef struct packed {
    logic             fs_meta;
    logic             fs_sync;
    logic             pwr_meta;
    logic             pwr_sync;
    logic             trip_meta;
    logic             trip_sync;
    logic             wrn_meta;
    logic             wrn_sync;
    logic [1:0]       sel_meta;
    logic [1:0]       sel_sync;
    logic             fstop;
    logic             conv_alarm;
    logic [CNT_W-1:0] cnt;
    logic             cnt_done;
    logic             fault_ok;
    logic             warning;
    logic             coil;
    logic             servo_off;
    logic             mpo_warn;
    logic             mc_en;
  } cacs_conv_state_type;

  // reset value: forced stop held, servo-off requested and other outputs inactive until inputs are seen
  localparam cacs_conv_state_type CONV_RST = '{
    fs_meta:    1'b0,
    fs_sync:    1'b0,
    pwr_meta:   1'b0,
    pwr_sync:   1'b0,
    trip_meta:  1'b0,
    trip_sync:  1'b0,
    wrn_meta:   1'b0,
    wrn_sync:   1'b0,
    sel_meta:   CTRL_SEL_DISABLED,
    sel_sync:   CTRL_SEL_DISABLED,
    fstop:      1'b1,
    conv_alarm: 1'b0,
    cnt:        '0,
    cnt_done:   1'b0,
    fault_ok:   1'b0,
    warning:    1'b0,
    coil:       1'b0,
    servo_off:  1'b1,
    mpo_warn:   1'b0,
    mc_en:      1'b0
  };

  cacs_conv_state_type st_ff;
  cacs_conv_state_type nxt_st;

  logic mc_sel_en;
  logic main_ok;

  // contactor drive enable follows the synchronised select; zero hands control outside,
  // and the reset value is the disabled one so the coil cannot close before it is seen
  assign mc_sel_en = (st_ff.sel_sync != CTRL_SEL_DISABLED); // R08

  // main power may be applied only with no stop and no alarm on either side
  assign main_ok = !st_ff.fstop && !st_ff.conv_alarm && !link.drive_alarm; // R15

  // next state of the whole converter end
  always_comb begin
    nxt_st = st_ff;

    // two-stage synchronisers for all pins
    nxt_st.fs_meta   = forced_stop_in_i;
    nxt_st.fs_sync   = st_ff.fs_meta;
    nxt_st.pwr_meta  = power_ok_i;
    nxt_st.pwr_sync  = st_ff.pwr_meta;
    nxt_st.trip_meta = prot_trip_i;
    nxt_st.trip_sync = st_ff.trip_meta;
    nxt_st.wrn_meta  = warn_cond_i;
    nxt_st.wrn_sync  = st_ff.wrn_meta;
    nxt_st.sel_meta  = contactor_ctrl_select_i;
    nxt_st.sel_sync  = st_ff.sel_meta;

    // forced stop is a level state: low input enters it, high input leaves it
    if (!st_ff.fs_sync) begin
      nxt_st.fstop = 1'b1; // R01
    end else begin
      nxt_st.fstop = 1'b0; // R03
    end

    // converter alarm: latched on a trip, cleared by the drive's request
    // only when the cause has gone; a trip in the clear cycle wins
    if (st_ff.trip_sync) begin
      nxt_st.conv_alarm = 1'b1; // R11
    end else if (link.alarm_clear) begin
      nxt_st.conv_alarm = 1'b0; // R10
    end

    // power-on delay counter; restarts whenever control power drops
    if (!st_ff.pwr_sync) begin
      nxt_st.cnt      = '0;
      nxt_st.cnt_done = 1'b0;
    end else if (!st_ff.cnt_done) begin
      if (st_ff.cnt == DELAY_TC) begin
        nxt_st.cnt_done = 1'b1; // R22
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1; // R22
      end
    end

    // fault-ok: high after the delay with no alarm, low on power loss or trip
    nxt_st.fault_ok = st_ff.cnt_done && st_ff.pwr_sync
                      && !st_ff.conv_alarm && !st_ff.trip_sync; // R04 R05

    // warning output: external warning condition or forced stop held
    nxt_st.warning = st_ff.wrn_sync || st_ff.fstop; // R06

    // main power off warning to the drive, released as soon as stop ends
    nxt_st.mpo_warn = st_ff.fstop; // R02 R21

    // servo-on forced inactive by stop or converter alarm in either mode
    nxt_st.servo_off = st_ff.fstop || st_ff.conv_alarm; // R02 R09 R16

    // coil energized on the drive's start command, only in enabled mode;
    // in disabled mode the coil stays off and an outside sequence rules power
    nxt_st.mc_en = mc_sel_en;
    if (mc_sel_en) begin
      nxt_st.coil = link.start_req && main_ok; // R07 R09 R15 R02
    end else begin
      nxt_st.coil = 1'b0; // R16
    end
  end

  // single state register on the system clock, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= CONV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs taken straight from the state register
  assign fault_ok_out_o          = st_ff.fault_ok;
  assign warning_out_o           = st_ff.warning;
  assign contactor_coil_switch_o = st_ff.coil;

  // link outputs, also registered
  assign link.conv_alarm    = st_ff.conv_alarm;
  assign link.mpo_warn      = st_ff.mpo_warn;
  assign link.servo_off_req = st_ff.servo_off;
  assign link.main_power_on = st_ff.coil;
  assign link.mc_drive_en   = st_ff.mc_en;

endmodule : cacs_conv

// ---- rtl/cacs_pkg.sv ----
// shared constants for the converter alarm and contactor sequencer
//
// Contract
// R01: forced stop input low enters forced stop
// R02: forced stop drops contactor, warns, servo off
// R03: forced stop input high clears forced stop
// R04: fault-ok low on power loss or trip
// R05: fault-ok high 1.5 s after power-on
// R06: warning output follows warning condition
// R07: drive start command energizes contactor coil
// R08: select zero disables converter contactor drive
// R09: converter alarm drops contactor, stops drive
// R10: converter alarm cleared by drive request
// R11: alarm stays latched while cause present
// R12: drive alarm shuts off power stage gating
// R13: drive alarm activates fitted dynamic brake
// R14: drive alarm cleared by error/processor reset
// R15: main power only after start-up, no alarms
// R16: disabled drive: alarm gives servo-off only
// R17: external sequence removes power on alarm
// R18: clear converter, then drive, then reset
// R19: drive alarm cancelled before error reset
// R20: external power reapplied only without alarm
// R21: forced stop input high releases warning
// R22: one clock, power-on reset, parameter delay
package cacs_pkg;

  // timing of the fault-ok delay after power-on
  localparam int unsigned CLK_HZ            = 125_000_000;
  localparam int unsigned FAULT_OK_DELAY_MS = 1500;
  localparam int unsigned FAULT_OK_CYCLES   = (CLK_HZ / 1000) * FAULT_OK_DELAY_MS;
  localparam int unsigned CNT_W             = 28;

  // contactor control select value that disables the converter drive
  localparam logic [1:0] CTRL_SEL_DISABLED  = 2'h0;

  // drive start-up time after reset, in cycles
  localparam logic [3:0] STARTUP_CYCLES     = 4'hf;

  // wishbone register map of the drive end
  localparam logic [3:0] ADR_CTRL           = 4'h0;
  localparam logic [3:0] ADR_STATUS         = 4'h4;

  // control register fields
  localparam int unsigned CTRL_START_BIT    = 0;
  localparam int unsigned CTRL_SERVO_BIT    = 1;
  localparam int unsigned CTRL_ERR_RST_BIT  = 2;
  localparam int unsigned CTRL_CPU_RST_BIT  = 3;
  localparam int unsigned CTRL_DB_FIT_BIT   = 4;

  // status register fields
  localparam int unsigned ST_DRV_ALM_BIT    = 0;
  localparam int unsigned ST_CONV_ALM_BIT   = 1;
  localparam int unsigned ST_MPO_WARN_BIT   = 2;
  localparam int unsigned ST_GATE_BIT       = 3;
  localparam int unsigned ST_MAIN_PWR_BIT   = 4;
  localparam int unsigned ST_NEED_RST_BIT   = 5;
  localparam int unsigned ST_READY_BIT      = 6;
  localparam int unsigned ST_MC_EN_BIT      = 7;

endpackage : cacs_pkg

// ---- rtl/cacs_link_if.sv ----
// link between the converter end and the drive end
`timescale 1ns/1ps
interface cacs_link_if;
  logic start_req;      // drive start-up done and start asked
  logic drive_alarm;    // drive holds an alarm
  logic alarm_clear;    // one-cycle clear request for converter alarm
  logic conv_alarm;     // converter holds an alarm
  logic mpo_warn;       // main power off warning to drive
  logic servo_off_req;  // converter forces servo-on inactive
  logic main_power_on;  // converter contactor coil energized
  logic mc_drive_en;    // converter contactor drive enabled

  modport conv (
    input  start_req, drive_alarm, alarm_clear,
    output conv_alarm, mpo_warn, servo_off_req, main_power_on, mc_drive_en
  );

  modport drive (
    output start_req, drive_alarm, alarm_clear,
    input  conv_alarm, mpo_warn, servo_off_req, main_power_on, mc_drive_en
  );
endinterface : cacs_link_if

// ---- rtl/cacs_drive.sv ----
// drive end: drive alarm, power stage gating, brake, external contactor, wishbone registers
`timescale 1ns/1ps
module cacs_drive (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  cacs_link_if.drive       link,
  input  wire logic        drive_fault_i,      // pin, drive protective condition
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             gate_en_o,          // power stage gating enable
  output logic             dyn_brake_o,        // external dynamic brake on
  output logic             ext_contactor_o     // external sequence contactor
);
  import cacs_pkg::*;

  typedef struct packed {
    logic        flt_meta;
    logic        flt_sync;
    logic [3:0]  startup;
    logic        ready;
    logic        start;
    logic        servo_cmd;
    logic        db_fitted;
    logic        drv_alarm;
    logic        need_rst;
    logic        clear;
    logic        gate;
    logic        brake;
    logic        ext_mc;
    logic        ack;
    logic [31:0] rdata;
  } cacs_drive_state_type;

  localparam cacs_drive_state_type DRV_RST = '{
    flt_meta: 1'b0, flt_sync: 1'b0, startup: '0, ready: 1'b0, start: 1'b0,
    servo_cmd: 1'b0, db_fitted: 1'b0, drv_alarm: 1'b0, need_rst: 1'b0,
    clear: 1'b0, gate: 1'b0, brake: 1'b0, ext_mc: 1'b0, ack: 1'b0, rdata: '0
  };

  cacs_drive_state_type st_ff;
  cacs_drive_state_type nxt_st;

  logic wr_ctrl;
  logic rst_cmd;
  logic any_alarm;

  // a write is taken in the cycle ack is raised; byte lane 0 holds all fields
  assign wr_ctrl   = cyc_i && stb_i && !st_ff.ack && we_i && (adr_i == ADR_CTRL) && sel_i[0];
  assign rst_cmd   = wr_ctrl && (dat_i[CTRL_ERR_RST_BIT] || dat_i[CTRL_CPU_RST_BIT]);
  assign any_alarm = st_ff.drv_alarm || link.conv_alarm;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.flt_meta = drive_fault_i;
    nxt_st.flt_sync = st_ff.flt_meta;

    // start-up delay before the drive may ask for main power
    if (st_ff.startup != STARTUP_CYCLES) begin
      nxt_st.startup = st_ff.startup + 1'b1;
    end else begin
      nxt_st.ready = 1'b1;
    end

    // control register; reset commands are pulses, not stored
    if (wr_ctrl) begin
      nxt_st.start     = dat_i[CTRL_START_BIT];
      nxt_st.servo_cmd = dat_i[CTRL_SERVO_BIT];
      nxt_st.db_fitted = dat_i[CTRL_DB_FIT_BIT];
    end

    // drive alarm latched while its cause stands; set wins over a reset command
    if (st_ff.flt_sync) begin
      nxt_st.drv_alarm = 1'b1; // R11
    end else if (rst_cmd) begin
      nxt_st.drv_alarm = 1'b0; // R14
    end

    // servo stays off after any alarm until a reset issued with alarms cancelled
    if (st_ff.flt_sync || link.conv_alarm) begin
      nxt_st.need_rst = 1'b1; // R18 R19
    end else if (rst_cmd && !st_ff.drv_alarm) begin
      nxt_st.need_rst = 1'b0; // R19
    end

    // the reset command also requests the converter to clear its alarm
    nxt_st.clear = rst_cmd; // R10 R14

    // gating off on alarm so the motor coasts; brake only if fitted
    nxt_st.gate  = st_ff.servo_cmd && !st_ff.drv_alarm && !st_ff.need_rst
                   && !link.servo_off_req && !link.mpo_warn; // R12 R16
    nxt_st.brake = st_ff.db_fitted && st_ff.drv_alarm; // R13

    // external contactor used only when converter drive is disabled
    nxt_st.ext_mc = !link.mc_drive_en && st_ff.start && !any_alarm; // R17 R20

    // classic wishbone: ack one cycle after the request, dropped next cycle
    nxt_st.ack   = cyc_i && stb_i && !st_ff.ack;
    nxt_st.rdata = '0;
    if (cyc_i && stb_i && !st_ff.ack && !we_i) begin
      if (adr_i == ADR_CTRL) begin
        nxt_st.rdata[CTRL_START_BIT]  = st_ff.start;
        nxt_st.rdata[CTRL_SERVO_BIT]  = st_ff.servo_cmd;
        nxt_st.rdata[CTRL_DB_FIT_BIT] = st_ff.db_fitted;
      end else if (adr_i == ADR_STATUS) begin
        nxt_st.rdata[ST_DRV_ALM_BIT]  = st_ff.drv_alarm;
        nxt_st.rdata[ST_CONV_ALM_BIT] = link.conv_alarm;
        nxt_st.rdata[ST_MPO_WARN_BIT] = link.mpo_warn;
        nxt_st.rdata[ST_GATE_BIT]     = st_ff.gate;
        nxt_st.rdata[ST_MAIN_PWR_BIT] = link.main_power_on || st_ff.ext_mc;
        nxt_st.rdata[ST_NEED_RST_BIT] = st_ff.need_rst;
        nxt_st.rdata[ST_READY_BIT]    = st_ff.ready;
        nxt_st.rdata[ST_MC_EN_BIT]    = link.mc_drive_en;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= DRV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // start request only after start-up completes
  assign link.start_req   = st_ff.start && st_ff.ready; // R15
  assign link.drive_alarm = st_ff.drv_alarm;
  assign link.alarm_clear = st_ff.clear;

  assign dat_o           = st_ff.rdata;
  assign ack_o           = st_ff.ack;
  assign gate_en_o       = st_ff.gate;
  assign dyn_brake_o     = st_ff.brake;
  assign ext_contactor_o = st_ff.ext_mc;

endmodule : cacs_drive

// ---- tb/cacs_asserts.sv ----
// concurrent checks on the link between the converter end and the drive end
`timescale 1ns/1ps
module cacs_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_req,
  input wire logic drive_alarm,
  input wire logic alarm_clear,
  input wire logic conv_alarm,
  input wire logic mpo_warn,
  input wire logic servo_off_req,
  input wire logic main_power_on,
  input wire logic mc_drive_en
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // start held clean for three cycles; forced stop may still win at the last edge
  sequence clean_start;
    (start_req && mc_drive_en && !drive_alarm && !conv_alarm && !mpo_warn) [*3];
  endsequence
  sequence coil_or_stop;
    main_power_on || mpo_warn;
  endsequence

  chk_start_closes_coil: assert property (clean_start |=> coil_or_stop)
    else $error("coil not energized after clean start");
  chk_coil_needs_start: assert property (main_power_on |-> $past(start_req) && !$past(drive_alarm)
    && !$past(conv_alarm))
    else $error("coil energized without start or with alarm");
  chk_no_coil_disabled: assert property (!mc_drive_en |-> !main_power_on)
    else $error("coil energized with contactor drive disabled");
  chk_fstop_servo_off: assert property (mpo_warn |-> servo_off_req)
    else $error("forced stop without servo off");
  chk_fstop_drops_coil: assert property (mpo_warn |-> !main_power_on)
    else $error("coil energized in forced stop");
  chk_conv_alarm_coil: assert property (conv_alarm |=> !main_power_on)
    else $error("coil kept with converter alarm");
  chk_drive_alarm_coil: assert property (drive_alarm |=> !main_power_on)
    else $error("coil kept with drive alarm");
  // the converter alarm only goes away through a clear pulse in this bench
  chk_alarm_held: assert property (conv_alarm && !alarm_clear |=> conv_alarm)
    else $error("converter alarm dropped without clear");
  chk_clear_one_cycle: assert property ($rose(alarm_clear) |=> $fell(alarm_clear))
    else $error("clear request longer than one cycle");
endmodule : cacs_asserts

// ---- tb/cacs_tb_top.sv ----
// self-checking bench for both sequencer ends joined by their link
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module cacs_tb_top;
  import cacs_pkg::*;
  localparam logic [31:0] RUN = 32'h03; // start and servo on
  localparam logic [31:0] ERR = 32'h07; // run plus error reset pulse
  localparam logic [31:0] DBF = 32'h13; // run with dynamic brake fitted
  localparam logic [31:0] CPU = 32'h1b; // brake fitted plus processor reset pulse
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        forced_stop_in = 1'b1, pwr_ok = 1'b1, trip = 1'b0, warn = 1'b0, dfault = 1'b0;
  logic [1:0]  csel = 2'h1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, fault_ok, warn_o, coil, gate, brake, ext_mc;
  int          err_total = 0, n_compared = 0;

  always #4 clk_i = ~clk_i;

  cacs_link_if link_i ();
  cacs_conv #(.FAULT_OK_CYCLES_P(20)) cacs_conv_i (.clk_i(clk_i), .rst_i(rst_i), .link(link_i),
    .forced_stop_in_i(forced_stop_in), .power_ok_i(pwr_ok), .prot_trip_i(trip), .warn_cond_i(warn),
    .contactor_ctrl_select_i(csel), .fault_ok_out_o(fault_ok), .warning_out_o(warn_o),
    .contactor_coil_switch_o(coil));
  cacs_drive cacs_drive_i (.clk_i(clk_i), .rst_i(rst_i), .link(link_i), .drive_fault_i(dfault),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .gate_en_o(gate), .dyn_brake_o(brake), .ext_contactor_o(ext_mc));
  cacs_asserts cacs_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .start_req(link_i.start_req),
    .drive_alarm(link_i.drive_alarm), .alarm_clear(link_i.alarm_clear), .conv_alarm(link_i.conv_alarm),
    .mpo_warn(link_i.mpo_warn), .servo_off_req(link_i.servo_off_req),
    .main_power_on(link_i.main_power_on), .mc_drive_en(link_i.mc_drive_en));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // classic cycle: request held until ack is sampled, released at that edge
  task automatic wb(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, wr, adr, 4'hf, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (n >= 40) err_total++;
  endtask : wb

  task automatic st(input int idx, input logic exp);
    wb(1'b0, ADR_STATUS, 32'h0);
    `CHK(rd[idx], exp)
  endtask : st

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    tick(5000);
    err_total++;
    end_of_test();
  end

  initial begin
    tick(20);
    rst_i <= 1'b0;
    tick(8);
    `CHK(fault_ok, 1'b0)
    tick(30);
    `CHK(fault_ok, 1'b1)
    $display("done: power-on");
    st(ST_READY_BIT, 1'b1);
    wb(1'b1, ADR_CTRL, RUN);
    tick(4);
    `CHK({coil, gate, ext_mc}, 3'b110)
    st(ST_MC_EN_BIT, 1'b1);
    wb(1'b0, ADR_CTRL, 32'h0);
    `CHK(rd, RUN)
    $display("done: start");
    forced_stop_in <= 1'b0;
    tick(6);
    `CHK({coil, gate, warn_o}, 3'b001)
    st(ST_MPO_WARN_BIT, 1'b1);
    forced_stop_in <= 1'b1;
    tick(6);
    `CHK({coil, warn_o}, 2'b10)
    st(ST_MPO_WARN_BIT, 1'b0);
    warn <= 1'b1;
    tick(6);
    `CHK(warn_o, 1'b1)
    warn <= 1'b0;
    tick(6);
    `CHK(warn_o, 1'b0)
    $display("done: forced stop and warning");
    trip <= 1'b1;
    tick(6);
    `CHK({coil, gate}, 2'b00)
    `CHK(fault_ok, 1'b0)
    st(ST_NEED_RST_BIT, 1'b1);
    wb(1'b1, ADR_CTRL, ERR);
    st(ST_CONV_ALM_BIT, 1'b1);
    trip <= 1'b0;
    tick(6);
    wb(1'b1, ADR_CTRL, ERR);
    st(ST_CONV_ALM_BIT, 1'b0);
    tick(4);
    `CHK(coil, 1'b1)
    wb(1'b1, ADR_CTRL, ERR);
    tick(4);
    `CHK(gate, 1'b1)
    $display("done: converter alarm");
    wb(1'b1, ADR_CTRL, DBF);
    `CHK(brake, 1'b0)
    dfault <= 1'b1;
    tick(6);
    `CHK(gate, 1'b0)
    `CHK(brake, 1'b1)
    `CHK(coil, 1'b0)
    wb(1'b1, ADR_CTRL, CPU);
    st(ST_DRV_ALM_BIT, 1'b1);
    dfault <= 1'b0;
    tick(6);
    wb(1'b1, ADR_CTRL, CPU);
    st(ST_DRV_ALM_BIT, 1'b0);
    $display("done: drive alarm");
    // select is static, so it changes only under reset
    rst_i <= 1'b1;
    csel <= CTRL_SEL_DISABLED;
    tick(20);
    rst_i <= 1'b0;
    tick(40);
    wb(1'b1, ADR_CTRL, RUN);
    tick(4);
    `CHK({coil, ext_mc}, 2'b01)
    st(ST_MC_EN_BIT, 1'b0);
    st(ST_MAIN_PWR_BIT, 1'b1);
    dfault <= 1'b1;
    tick(6);
    `CHK({coil, ext_mc, gate}, 3'b000)
    dfault <= 1'b0;
    tick(6);
    wb(1'b1, ADR_CTRL, CPU);
    wb(1'b1, ADR_CTRL, ERR);
    tick(4);
    `CHK({ext_mc, gate}, 2'b11)
    trip <= 1'b1;
    tick(6);
    `CHK({coil, ext_mc, gate}, 3'b000)
    trip <= 1'b0;
    tick(6);
    wb(1'b1, ADR_CTRL, ERR);
    wb(1'b1, ADR_CTRL, ERR);
    tick(4);
    `CHK({ext_mc, gate}, 2'b11)
    $display("done: contactor drive disabled");
    pwr_ok <= 1'b0;
    tick(6);
    `CHK(fault_ok, 1'b0)
    $display("done: power loss");
    end_of_test();
  end
endmodule : cacs_tb_top
